// file: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    import tsi_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic timeout_en = 1'b0;
    logic pec_en = 1'b0;
    logic temp_new_vld = 1'b0;
    logic [15:0] temp_new = 16'h0000;
    logic [6:0] tgt_addr = 7'h2C;
    logic scl, sda_dn, sda_o, sda_oe, cfg_wr_r;
    logic [15:0] temp_r, cfg_r;
    logic [7:0] w;
    wire sda;
    int fails = 0;
    int num_checks = 0;
    int pulses = 0;

    always #2 mclk = ~mclk;
    assign w = {tgt_addr, 1'b0};
    // wire level: pull-up unless either party pulls low
    assign sda = ~(sda_dn | (sda_oe & ~sda_o));
    always @(posedge mclk)
        if (cfg_wr_r === 1'b1)
            pulses++;

    tsi_bus_master m (.scl(scl), .sda_dn(sda_dn), .sda(sda));
    tsi_target #(.TIMEOUT_CYCLES(200)) dut (
        .mclk(mclk), .rst_n(rst_n), .scl_clk(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .tgt_addr(tgt_addr),
        .timeout_en(timeout_en), .pec_en(pec_en), .temp_new(temp_new),
        .temp_new_vld(temp_new_vld), .temp_r(temp_r), .cfg_r(cfg_r),
        .cfg_wr_r(cfg_wr_r));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk

    // bitwise model kept apart from the design's own update logic
    function automatic logic [7:0] crc(input logic [7:0] c,
                                       input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? {r[6:0], 1'b0} ^ CRC_POLY : {r[6:0], 1'b0};
        return r;
    endfunction : crc

    // check byte runs over everything already queued, earlier checks too
    task automatic add_pec(ref logic [7:0] q[$]);
        logic [7:0] c;
        c = CRC_INIT;
        foreach (q[i])
            c = crc(c, q[i]);
        q.push_back(c);
    endtask : add_pec

    task automatic send(input logic [7:0] q[$], input logic want);
        logic a;
        m.start();
        foreach (q[i])
        begin
            m.wr_byte(q[i], a);
            if (want)
                chk("ack", 16'h0001, {15'h0, a});
        end
        m.stop();
        repeat (20) @(posedge mclk);
    endtask : send

    task automatic rd(input logic [7:0] p, output logic [15:0] v);
        logic a;
        m.start();
        m.wr_byte(w, a);
        m.wr_byte(p, a);
        m.start();
        m.wr_byte({tgt_addr, 1'b1}, a);
        m.rd_byte(1'b0, v[15:8]);
        m.rd_byte(1'b1, v[7:0]);
        m.stop();
        repeat (20) @(posedge mclk);
    endtask : rd

    task automatic pulse(input logic [15:0] t);
        @(posedge mclk);
        temp_new <= t;
        temp_new_vld <= 1'b1;
        @(posedge mclk);
        temp_new_vld <= 1'b0;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    // plain writes, read-back, read-only temperature and a foreign address
    task automatic t_write();
        logic [15:0] v;
        logic a;
        pulses = 0;
        send('{w, PTR_CFG, 8'hA5, 8'h3C}, 1'b1);
        chk("cfg", 16'hA53C, cfg_r);
        chk("wr pulses", 16'h0001, 16'(pulses));
        rd(PTR_CFG, v);
        chk("cfg read", 16'hA53C, v);
        send('{w, PTR_CFG, 8'h12, 8'h34, 8'h56, 8'h78}, 1'b1);
        chk("cfg twice", 16'h5678, cfg_r);
        send('{w, PTR_TEMP, 8'hFF, 8'hFF}, 1'b0);
        chk("temp ro", TEMP_RST, temp_r);
        m.start();
        m.wr_byte({~tgt_addr, 1'b0}, a);
        chk("foreign nack", 16'h0000, {15'h0, a});
        m.stop();
        chk("drive level", 16'h0000, {15'h0, sda_o});
    endtask : t_write

    // checked writes: good, two groups, corrupt check, short count
    task automatic t_pec();
        logic [7:0] q[$];
        @(posedge mclk);
        pec_en <= 1'b1;
        q = '{w, PTR_CFG, 8'h11, 8'h22};
        add_pec(q);
        send(q, 1'b1);
        chk("pec one", 16'h1122, cfg_r);
        q = '{w, PTR_CFG, 8'h33, 8'h44};
        add_pec(q);
        q.push_back(8'h55);
        q.push_back(8'h66);
        add_pec(q);
        send(q, 1'b1);
        chk("pec two", 16'h5566, cfg_r);
        q = '{w, PTR_CFG, 8'h77, 8'h88};
        add_pec(q);
        q[4] = q[4] ^ 8'h01;
        send(q, 1'b0);
        chk("pec bad", 16'h5566, cfg_r);
        send('{w, PTR_CFG, 8'h99, 8'hAA}, 1'b0);
        chk("pec short", 16'h5566, cfg_r);
        @(posedge mclk);
        pec_en <= 1'b0;
    endtask : t_pec

    // a new result during a temperature read waits for the read to end
    task automatic t_freeze();
        logic [15:0] v;
        pulse(16'h0C80);
        repeat (4) @(posedge mclk);
        chk("temp idle", 16'h0C80, temp_r);
        fork
            rd(PTR_TEMP, v);
            begin
                #1150;
                pulse(16'h1234);
                repeat (4) @(posedge mclk);
                chk("temp held", 16'h0C80, temp_r);
            end
        join
        chk("temp read", 16'h0C80, v);
        chk("temp after", 16'h1234, temp_r);
    endtask : t_freeze

    // clock parked low in the answer slot, watchdog on then off
    task automatic t_timeout();
        logic s;
        for (int en = 1; en >= 0; en--)
        begin
            @(posedge mclk);
            timeout_en <= en[0];
            m.start();
            for (int i = 7; i >= 0; i--)
                m.clk_bit(w[i], s);
            #100 chk("ack out", 16'h0001, {15'h0, sda_oe});
            #2000 chk("ack hold", {15'h0, ~en[0]}, {15'h0, sda_oe});
            m.clk_bit(1'b1, s);
            m.stop();
            repeat (20) @(posedge mclk);
        end
    endtask : t_timeout

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (40) @(posedge mclk);
        t_write();
        t_pec();
        t_freeze();
        t_timeout();
        stop_test();
    end

    // hang guard: far beyond the longest scenario
    initial
    begin
        repeat (100000) @(posedge mclk);
        fails++;
        stop_test();
    end
endmodule : testbench

// file: dv/tsi_bus_master.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// bus master stand-in: clock moves only inside frames, data is open drain
module tsi_bus_master
(
    output logic scl,
    output logic sda_dn,
    input wire logic sda
);
    // idle: clock high, data released to the pull-up
    initial
    begin
        scl = 1'b1;
        sda_dn = 1'b0;
    end

    // one bit: data set while clock low, sampled late in the high phase
    task automatic clk_bit(input logic b, output logic s);
        sda_dn = ~b;
        #16 scl = 1'b1;
        #15 s = sda;
        #1 scl = 1'b0;
    endtask : clk_bit

    // start and repeated start share one path: release, clock high, pull
    task automatic start();
        sda_dn = 1'b0;
        #16 scl = 1'b1;
        #16 sda_dn = 1'b1;
        #16 scl = 1'b0;
    endtask : start

    // stop: data low under a low clock, then released while clock is high
    task automatic stop();
        sda_dn = 1'b1;
        #16 scl = 1'b1;
        #16 sda_dn = 1'b0;
        #32;
    endtask : stop

    // byte out, most significant bit first, ninth clock reads the answer
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : wr_byte

    // byte in; the last one is refused so the target lets go of the line
    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            clk_bit(1'b1, s);
            b[i] = s;
        end
        clk_bit(last, s);
    endtask : rd_byte
endmodule : tsi_bus_master

// file: logic/tsi_crc8.sv
`timescale 1ns/1ns
// smbus check byte update, one whole byte per call
module tsi_crc8
(
    input wire logic [7:0] crc_in,
    input wire logic [7:0] data,
    output logic [7:0] crc_out
);
    import tsi_pkg::*;

    // msb first shift over x^8+x^2+x+1
    always_comb
    begin
        logic [7:0] c;
        c = crc_in ^ data;
        for (int i = 0; i < 8; i++)
        begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        crc_out = c;
    end
endmodule : tsi_crc8

// file: logic/tsi_pkg.sv
package tsi_pkg;
    // bus timeout window, the shortest figure that still resets the port
    localparam int TIMEOUT_MS = 14;
    // the watchdog counts system clock cycles, not link cycles
    localparam int MCLK_HZ = 250_000_000;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (MCLK_HZ / 1000);
    localparam logic [6:0] TGT_ADDR_RST = 7'h48;
    localparam logic [15:0] TEMP_RST = 16'h0000;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_CFG = 8'h01;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h8;
endpackage : tsi_pkg

// file: logic/tsi_target.sv
`timescale 1ns/1ns
module tsi_target
#(
    parameter int TIMEOUT_CYCLES = tsi_pkg::TIMEOUT_CYC
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [6:0] tgt_addr,
    input wire logic timeout_en,
    input wire logic pec_en,
    input wire logic [15:0] temp_new,
    input wire logic temp_new_vld,
    output logic [15:0] temp_r,
    output logic [15:0] cfg_r,
    output logic cfg_wr_r
);
    import tsi_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset release on the system clock
    logic rst_s1_r, rst_s2_r;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    wire logic rstn_m = rst_s2_r;

    // link side reset: scl may not tick for a long time after power-up,
    // so a synchroniser on scl would eat the first address bits; the
    // release lands while the bus idles with scl parked high
    wire logic lrstn_m = rst_s2_r;

    ////////////////////////////////////////////////////////////////////////
    // data line sampled into mclk, three stages, second and third agree
    logic [2:0] sda_sy_r;
    logic sda_r;
    logic scl_s1_r, scl_s2_r, scl_s3_r, scl_r;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sda_sy_r <= 3'h7;
            sda_r <= 1'b1;
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_s3_r <= 1'b1;
            scl_r <= 1'b1;
        end
        else
        begin
            sda_sy_r <= {sda_sy_r[1:0], sda_i};
            if (sda_sy_r[1] == sda_sy_r[2])
                sda_r <= sda_sy_r[2];
            scl_s1_r <= scl_clk;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            if (scl_s2_r == scl_s3_r)
                scl_r <= scl_s3_r;
        end
    end

    // start and stop are data edges while the clock sits high
    logic sda_d_r;
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            sda_d_r <= 1'b1;
        else
            sda_d_r <= sda_r;
    end
    wire logic start_m = scl_r && sda_d_r && !sda_r;
    wire logic stop_m = scl_r && !sda_d_r && sda_r;

    ////////////////////////////////////////////////////////////////////////
    // clock low watchdog; the clock may stop so this runs on mclk
    logic [$clog2(TIMEOUT_CYCLES+1)-1:0] tmo_cnt_r;
    logic tmo_r;
    always_ff @(posedge mclk or negedge rstn_m)
    begin
        if (!rstn_m)
        begin
            tmo_cnt_r <= '0;
            tmo_r <= 1'b0;
        end
        else if (scl_r || !timeout_en)
        begin
            tmo_cnt_r <= '0;
            tmo_r <= 1'b0;
        end
        else if (tmo_cnt_r == TIMEOUT_CYCLES[$bits(tmo_cnt_r)-1:0])
            tmo_r <= 1'b1;
        else
            tmo_cnt_r <= tmo_cnt_r + 1'b1;
    end

    // start events as a toggle, taken over by the link side
    logic frm_tgl_r;
    always_ff @(posedge mclk or negedge rstn_m)
    begin
        if (!rstn_m)
            frm_tgl_r <= 1'b0;
        else if (start_m)
            frm_tgl_r <= ~frm_tgl_r;
    end
    // stop vs start kind, held steady between events
    logic frm_start_r;
    always_ff @(posedge mclk or negedge rstn_m)
    begin
        if (!rstn_m)
            frm_start_r <= 1'b0;
        else if (start_m)
            frm_start_r <= 1'b1;
        else if (stop_m || tmo_r)
            frm_start_r <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // link side: a full bit shifts on rising scl; the start toggle has
    // settled well before the first rising scl after a start, so one
    // stage takes it; deeper sync would lose the first address bits
    logic ft_seen_r;
    always_ff @(posedge scl_clk or negedge lrstn_m)
    begin
        if (!lrstn_m)
            ft_seen_r <= 1'b0;
        else
            ft_seen_r <= frm_tgl_r;
    end
    wire logic frm_evt = frm_tgl_r ^ ft_seen_r;

    typedef enum {ST_IDLE, ST_ADDR, ST_PTR, ST_WDAT, ST_RDAT, ST_SKIP}
        tsi_state_e;
    tsi_state_e st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r, ptr_r, hi_r, crc_r, txb_r;
    logic rd_r, hi_ph_r, ack_r, nack_r, radr_r;
    logic [1:0] grp_r;
    logic [15:0] wval_r;
    logic wpend_r;
    logic [7:0] crc_nxt;
    logic [7:0] byte_in;
    assign byte_in = {sh_r[6:0], sda_i};

    tsi_crc8 u_crc
    (
        .crc_in(crc_r),
        .data(byte_in),
        .crc_out(crc_nxt)
    );

    // register chosen by the pointer
    function automatic logic [15:0] tsi_sel(input logic [7:0] p,
        input logic [15:0] t, input logic [15:0] c);
        return (p == PTR_CFG) ? c : t;
    endfunction : tsi_sel

    // held temperature and config copies used for reading
    logic [15:0] rd_word;
    assign rd_word = tsi_sel(ptr_r, temp_r, cfg_r);

    // byte engine on the link clock
    always_ff @(posedge scl_clk or negedge lrstn_m)
    begin
        if (!lrstn_m)
        begin
            st_r <= ST_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= PTR_TEMP;
            hi_r <= 8'h00;
            crc_r <= CRC_INIT;
            rd_r <= 1'b0;
            hi_ph_r <= 1'b1;
            grp_r <= 2'h0;
            wval_r <= 16'h0000;
            wpend_r <= 1'b0;
            txb_r <= 8'h00;
            nack_r <= 1'b0;
            radr_r <= 1'b0;
        end
        else if (frm_evt)
        begin
            // a start restarts address collection, stop or timeout idles
            st_r <= ST_IDLE;
            if (frm_start_r)
            begin
                st_r <= ST_ADDR;
                sh_r <= {7'h00, sda_i};
                bit_r <= 4'h1;
            end
            else
                bit_r <= 4'h0;
            crc_r <= CRC_INIT;
            hi_ph_r <= 1'b1;
            grp_r <= 2'h0;
            wpend_r <= 1'b0;
        end
        else if (!frm_start_r)
            st_r <= ST_IDLE; // stop or timeout since the last start
        else if (st_r != ST_IDLE && st_r != ST_SKIP)
        begin
            if (bit_r == BIT_LAST)
                bit_r <= 4'h0; // ack slot
            else
                bit_r <= bit_r + 4'h1;
            if (bit_r < 4'h7 || (bit_r == 4'h7 && st_r == ST_RDAT))
                sh_r <= byte_in;
            if (st_r == ST_RDAT && bit_r == BIT_LAST)
                nack_r <= sda_i; // master ack of our byte
            if (bit_r == 4'h7 && st_r != ST_RDAT)
            begin
                crc_r <= crc_nxt;
                unique case (st_r)
                    ST_ADDR:
                    begin
                        if (byte_in[7:1] != tgt_addr)
                            st_r <= ST_SKIP;
                        else if (byte_in[0])
                        begin
                            st_r <= ST_RDAT;
                            rd_r <= 1'b1;
                            radr_r <= 1'b1; // address ack comes first
                            hi_ph_r <= 1'b1;
                        end
                        else
                        begin
                            st_r <= ST_PTR;
                            rd_r <= 1'b0;
                        end
                    end
                    ST_PTR:
                    begin
                        ptr_r <= byte_in;
                        st_r <= ST_WDAT;
                    end
                    ST_WDAT:
                    begin
                        if (pec_en && grp_r == 2'h2)
                        begin
                            grp_r <= 2'h0;
                            if (crc_nxt == 8'h00)
                                wpend_r <= 1'b1;
                        end
                        else if (hi_ph_r)
                        begin
                            hi_r <= byte_in;
                            hi_ph_r <= 1'b0;
                            grp_r <= grp_r + 2'h1;
                            wpend_r <= 1'b0;
                        end
                        else
                        begin
                            wval_r <= {hi_r, byte_in};
                            hi_ph_r <= 1'b1;
                            grp_r <= grp_r + 2'h1;
                            wpend_r <= !pec_en;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
            if (st_r == ST_RDAT && bit_r == BIT_LAST)
            begin
                if (sda_i)
                    st_r <= ST_SKIP;
                else
                begin
                    txb_r <= hi_ph_r ? rd_word[15:8] : rd_word[7:0];
                    hi_ph_r <= ~hi_ph_r;
                    radr_r <= 1'b0;
                end
            end
            else if (st_r == ST_RDAT)
                txb_r <= {txb_r[6:0], 1'b0};
        end
    end

    // acknowledge low and read bits, updated while scl is low
    always_ff @(negedge scl_clk or negedge lrstn_m)
    begin
        if (!lrstn_m)
            ack_r <= 1'b0;
        else if (st_r == ST_RDAT)
            ack_r <= radr_r || ((bit_r != BIT_LAST) && !txb_r[7]);
        else
            ack_r <= (bit_r == BIT_LAST) && (st_r == ST_PTR
                || st_r == ST_WDAT || st_r == ST_RDAT);
    end
    // driving low only, release otherwise; timeout forces release
    always_comb
    begin
        sda_o = 1'b0;
    end
    assign sda_oe = ack_r && !tmo_r;

    ////////////////////////////////////////////////////////////////////////
    // commit and read-busy cross back to mclk as levels
    logic wc1_r, wc2_r, wc3_r, rb1_r, rb2_r;
    wire logic rd_busy_l = (st_r == ST_RDAT) && (ptr_r == PTR_TEMP);
    always_ff @(posedge mclk or negedge rstn_m)
    begin
        if (!rstn_m)
        begin
            wc1_r <= 1'b0;
            wc2_r <= 1'b0;
            wc3_r <= 1'b0;
            rb1_r <= 1'b0;
            rb2_r <= 1'b0;
        end
        else
        begin
            wc1_r <= wpend_r && (ptr_r == PTR_CFG) && stop_m;
            wc2_r <= wc1_r;
            wc3_r <= wc2_r;
            rb1_r <= rd_busy_l;
            rb2_r <= rb1_r;
        end
    end

    // config write commits at stop; temperature only moves outside reads with the temperature pointer
    logic [15:0] temp_hold_r;
    logic hold_vld_r;
    always_ff @(posedge mclk or negedge rstn_m)
    begin
        if (!rstn_m)
        begin
            temp_r <= TEMP_RST;
            temp_hold_r <= TEMP_RST;
            hold_vld_r <= 1'b0;
            cfg_r <= CFG_RST;
            cfg_wr_r <= 1'b0;
        end
        else
        begin
            cfg_wr_r <= wc1_r && !wc2_r;
            if (wc1_r && !wc2_r)
                cfg_r <= wval_r;
            if (temp_new_vld)
            begin
                temp_hold_r <= temp_new;
                hold_vld_r <= 1'b1;
            end
            else if (hold_vld_r && !rb2_r)
            begin
                temp_r <= temp_hold_r;
                hold_vld_r <= 1'b0;
            end
        end
    end

    rd_hold_a: assert property (@(posedge mclk) disable iff (!rstn_m)
        rb2_r && $past(rb2_r) |-> $stable(temp_r))
        else $error("temperature moved during read");
    rel_tmo_a: assert property (@(posedge mclk) disable iff (!rstn_m)
        tmo_r |-> !sda_oe)
        else $error("data held low after timeout");
    tmo_off_a: assert property (@(posedge mclk) disable iff (!rstn_m)
        !timeout_en |=> !tmo_r)
        else $error("timeout while disabled");
    low_only_a: assert property (@(posedge mclk) disable iff (!rstn_m)
        sda_o == 1'b0)
        else $error("data driven high");
    cfg_pulse_a: assert property (@(posedge mclk) disable iff (!rstn_m)
        cfg_wr_r |=> !cfg_wr_r)
        else $error("config strobe too long");
    cfg_load_a: assert property (@(posedge mclk) disable iff (!rstn_m)
        cfg_wr_r |-> cfg_r == $past(wval_r))
        else $error("config not loaded");
    load_after_a: assert property (@(posedge mclk) disable iff (!rstn_m)
        hold_vld_r && !rb2_r && !temp_new_vld |=> temp_r == $past(temp_hold_r))
        else $error("pending temperature not loaded");
    stay_cfg_a: assert property (@(posedge mclk) disable iff (!rstn_m)
        !cfg_wr_r |=> $stable(cfg_r) || cfg_wr_r)
        else $error("config changed without write");
endmodule : tsi_target
